// ==== verilog/dpc_port_ctrl.sv ====
`timescale 1ns/1ns
`include "dpc_params.svh"

// Contract
// - Keep the write pulse active a hold time after the flag releases.
// - Hold both follower conflict inputs high for unrestricted access; the model has only the left one, inh_n, which t_inhibit drives low.
// - Start no follower write before the arbiter flag has settled.
// - Delay the write pulse by the maximum arbitration time.
module dpc_port_ctrl (
  input  wire logic                    clock_in,
  input  wire logic                    rst_in,
  input  wire logic                    ce_in,
  input  wire logic                    cmd_valid_in,
  input  wire dpc_pkg::dpc_cmd_s       cmd_in,
  output logic                         ready_out,
  output logic                         done_out,
  output logic                         conflict_out,
  output logic [`DPC_DATA_W-1:0]       rdata_out,
  output dpc_pkg::dpc_pins_s           pins_out,
  input  wire logic                    conflict_flag_n_in,
  input  wire logic [`DPC_DATA_W-1:0]  data_in,
  output logic [`DPC_DATA_W-1:0]       data_out,
  output logic                         data_oe_n_out
);
  import dpc_pkg::*;

  localparam int ARB_CYC = `DPC_SETTLE_CYC;
  localparam int WH_CYC  = `DPC_WH_CYC;

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [`DPC_DATA_W:0] pin_sync;
  logic                 flag_n;
  logic [`DPC_DATA_W-1:0] rd_sync;

  // The idle flag level is high, so reset loads a one there.
  dpc_sync #(.W(`DPC_DATA_W + 1)) u_sync (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .async_in     ({conflict_flag_n_in, data_in}),
    .reset_val_in ({1'b1, {`DPC_DATA_W{1'b0}}}),
    .sync_out     (pin_sync)
  );

  assign flag_n  = pin_sync[`DPC_DATA_W];
  assign rd_sync = pin_sync[`DPC_DATA_W-1:0];

  // ----------------------------------------------------------------
  // Access sequencer.
  // ----------------------------------------------------------------
  dpc_state_e               state_ff,     nxt_state;
  logic [`DPC_CNT_W-1:0]    cnt_ff,       nxt_cnt;
  dpc_cmd_s                 cmd_ff,       nxt_cmd;
  dpc_pins_s                pins_ff,      nxt_pins;
  logic [`DPC_DATA_W-1:0]   dout_ff,      nxt_dout;
  logic                     doe_n_ff,     nxt_doe_n;
  logic                     ready_ff,     nxt_ready;
  logic                     done_ff,      nxt_done;
  logic                     conf_ff,      nxt_conf;
  logic                     seen_ff,      nxt_seen;
  logic [`DPC_DATA_W-1:0]   rdata_ff,     nxt_rdata;

  // Next-state logic for the whole access sequence.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_cmd   = cmd_ff;
    nxt_pins  = pins_ff;
    nxt_dout  = dout_ff;
    nxt_doe_n = doe_n_ff;
    nxt_ready = ready_ff;
    nxt_done  = 1'b0;
    nxt_conf  = conf_ff;
    nxt_seen  = seen_ff;
    nxt_rdata = rdata_ff;
    if (ce_in) begin
      unique case (state_ff)
        DPC_IDLE: begin
          if (cmd_valid_in && ready_ff) begin
            nxt_cmd           = cmd_in;
            nxt_pins.addr     = cmd_in.addr;
            nxt_pins.select_n = 1'b0;
            nxt_cnt           = `DPC_CNT_W'(`DPC_SETTLE_CYC);
            nxt_seen          = 1'b0;
            nxt_ready         = 1'b0;
            nxt_state         = DPC_SETTLE;
          end
        end
        DPC_SETTLE: begin
          // The write strobe waits until arbitration has settled.
          if (cnt_ff <= `DPC_CNT_W'(1)) begin
            if (cmd_ff.write) begin
              nxt_pins.lower_lane_write_n = ~cmd_ff.lane[0];
              nxt_pins.upper_lane_write_n = ~cmd_ff.lane[1];
              nxt_dout  = cmd_ff.wdata;
              nxt_doe_n = 1'b0;
              nxt_cnt   = `DPC_CNT_W'(`DPC_WP_CYC);
              nxt_state = DPC_WRITE;
            end else begin
              nxt_pins.out_enable_n = 1'b0;
              nxt_cnt   = `DPC_CNT_W'(`DPC_RD_CYC);
              nxt_state = DPC_READ;
            end
          end else begin
            nxt_cnt = cnt_ff - `DPC_CNT_W'(1);
          end
        end
        DPC_WRITE: begin
          // A low flag restarts the hold count, so the strobe outlasts it.
          if (!flag_n) begin
            nxt_seen = 1'b1;
            nxt_cnt  = `DPC_CNT_W'(`DPC_WH_CYC);
          end else if (cnt_ff <= `DPC_CNT_W'(1)) begin
            nxt_pins.lower_lane_write_n = 1'b1;
            nxt_pins.upper_lane_write_n = 1'b1;
            nxt_pins.select_n = 1'b1;
            nxt_doe_n = 1'b1;
            nxt_conf  = seen_ff;
            nxt_done  = 1'b1;
            nxt_ready = 1'b1;
            nxt_state = DPC_IDLE;
          end else begin
            nxt_cnt = cnt_ff - `DPC_CNT_W'(1);
          end
        end
        DPC_READ: begin
          // Data read under contention may be stale; it is reported.
          if (!flag_n) begin
            nxt_seen = 1'b1;
          end
          if (cnt_ff <= `DPC_CNT_W'(1)) begin
            nxt_rdata             = rd_sync;
            nxt_pins.out_enable_n = 1'b1;
            nxt_pins.select_n     = 1'b1;
            nxt_conf  = seen_ff | ~flag_n;
            nxt_done  = 1'b1;
            nxt_ready = 1'b1;
            nxt_state = DPC_IDLE;
          end else begin
            nxt_cnt = cnt_ff - `DPC_CNT_W'(1);
          end
        end
        default: begin
          nxt_state = DPC_IDLE;
        end
      endcase
    end else begin
      nxt_done = done_ff;
    end
  end

  // Registers of the sequencer; reset parks every pin inactive.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= DPC_IDLE;
      cnt_ff   <= '0;
      cmd_ff   <= '0;
      pins_ff  <= '{addr: '0, select_n: 1'b1, out_enable_n: 1'b1,
                    lower_lane_write_n: 1'b1, upper_lane_write_n: 1'b1};
      dout_ff  <= '0;
      doe_n_ff <= 1'b1;
      ready_ff <= 1'b1;
      done_ff  <= 1'b0;
      conf_ff  <= 1'b0;
      seen_ff  <= 1'b0;
      rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      cmd_ff   <= nxt_cmd;
      pins_ff  <= nxt_pins;
      dout_ff  <= nxt_dout;
      doe_n_ff <= nxt_doe_n;
      ready_ff <= nxt_ready;
      done_ff  <= nxt_done;
      conf_ff  <= nxt_conf;
      seen_ff  <= nxt_seen;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs come straight from the registers.
  assign ready_out     = ready_ff;
  assign done_out      = done_ff;
  assign conflict_out  = conf_ff;
  assign rdata_out     = rdata_ff;
  assign pins_out      = pins_ff;
  assign data_out      = dout_ff;
  assign data_oe_n_out = doe_n_ff;

  // ----------------------------------------------------------------
  // Checks on the pin sequence.
  // ----------------------------------------------------------------
  logic [`DPC_CNT_W-1:0] sel_cnt_ff;
  logic [`DPC_CNT_W-1:0] hi_cnt_ff;
  logic                  wr_act;
  logic                  wr_end;

  assign wr_act = ~(pins_ff.lower_lane_write_n & pins_ff.upper_lane_write_n);
  assign wr_end = ce_in && state_ff == DPC_WRITE && nxt_state == DPC_IDLE;

  // Counts cycles selected, and cycles of a high flag during a write.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sel_cnt_ff <= '0;
      hi_cnt_ff  <= '0;
    end else if (ce_in) begin
      sel_cnt_ff <= pins_ff.select_n ? '0 : sel_cnt_ff + `DPC_CNT_W'(1);
      hi_cnt_ff  <= (state_ff == DPC_WRITE && flag_n) ? hi_cnt_ff + `DPC_CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  write_hold_a: assert property (wr_end |-> hi_cnt_ff >= `DPC_CNT_W'(WH_CYC - 1))
    else $error("write strobe released before hold time after flag");
  write_settle_a: assert property ($rose(wr_act) |-> sel_cnt_ff >= `DPC_CNT_W'(ARB_CYC))
    else $error("write strobe started before arbitration settled");
  arb_delay_a: assert property ($fell(pins_ff.select_n) && state_ff == DPC_SETTLE
                                |-> !wr_act [*8] ##1 !wr_act [*4])
    else $error("write strobe not delayed after select");
  flag_blocks_a: assert property (state_ff == DPC_WRITE && !flag_n && ce_in |=> wr_act)
    else $error("write strobe ended while conflict flag low");
  write_selected_a: assert property (wr_act |-> !pins_ff.select_n && pins_ff.out_enable_n)
    else $error("write strobe without select or with output enable");
  bus_turn_a: assert property (!doe_n_ff |-> pins_ff.out_enable_n)
    else $error("both ends drive the data lines");
  done_pulse_a: assert property (done_ff && ce_in |=> !done_ff)
    else $error("done held longer than one cycle");

  write_plain_c:    cover property (wr_end && !seen_ff);
  write_conflict_c: cover property (wr_end && seen_ff);
  read_done_c:      cover property (ce_in && state_ff == DPC_READ && nxt_state == DPC_IDLE);

endmodule

// ==== verilog/dpc_params.svh ====
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// ----------------------------------------------------------------
// Widths of the memory port and of the sequencer counter.
// ----------------------------------------------------------------
`define DPC_ADDR_W     11
`define DPC_DATA_W     16
`define DPC_CNT_W      8

// ----------------------------------------------------------------
// Timing in nanoseconds and derived clock cycles at 250 MHz.
// ----------------------------------------------------------------
`define DPC_CLK_NS     4
`define DPC_SYNC_CYC   2
`define DPC_ARB_NS     45
`define DPC_ARB_CYC    ((`DPC_ARB_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_WH_NS      30
`define DPC_WH_CYC     ((`DPC_WH_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_WP_NS      90
`define DPC_WP_CYC     ((`DPC_WP_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_RD_NS      90
`define DPC_RD_CYC     ((`DPC_RD_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS + `DPC_SYNC_CYC)
`define DPC_SETTLE_CYC (`DPC_ARB_CYC + `DPC_SYNC_CYC)

`endif

// ==== verilog/dpc_pkg.sv ====
`include "dpc_params.svh"

package dpc_pkg;

  // Request from the user side: one word access.
  typedef struct packed {
    logic                     write;
    logic [1:0]               lane;
    logic [`DPC_ADDR_W-1:0]   addr;
    logic [`DPC_DATA_W-1:0]   wdata;
  } dpc_cmd_s;

  // Control pins toward one memory port, all active low but the address.
  typedef struct packed {
    logic [`DPC_ADDR_W-1:0]   addr;
    logic                     select_n;
    logic                     out_enable_n;
    logic                     lower_lane_write_n;
    logic                     upper_lane_write_n;
  } dpc_pins_s;

  // Access sequencer states.
  typedef enum logic [3:0] {
    DPC_IDLE   = 4'b0001,
    DPC_SETTLE = 4'b0010,
    DPC_WRITE  = 4'b0100,
    DPC_READ   = 4'b1000
  } dpc_state_e;

endpackage

// ==== verilog/dpc_sync.sv ====
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Two flip-flop synchroniser for pin inputs.
// ----------------------------------------------------------------
module dpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_meta = ce_in ? async_in : meta_ff;
    nxt_sync = ce_in ? meta_ff : sync_ff;
  end

  // Reset loads the idle level the caller names.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_ff <= reset_val_in;
      sync_ff <= reset_val_in;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ==== tb/dpc_mem_model.sv ====
`timescale 1ns/1ns
`include "dpc_params.svh"

// ----------------------------------------------------------------
// Memory device model. The left port faces the controller; the
// right port only selects, so the bench can provoke contention.
// ----------------------------------------------------------------
module dpc_mem_model #(
  parameter int ARB_NS  = `DPC_ARB_NS,
  parameter int HOLD_NS = `DPC_WH_NS
) (
  input  wire dpc_pkg::dpc_pins_s     pins_in,
  input  wire logic [`DPC_DATA_W-1:0] dq_in,
  input  wire logic                   dq_oe_n_in,
  output logic [`DPC_DATA_W-1:0]      dq_out,
  output logic                        flag_n_out,
  input  wire logic                   r_select_n_in,
  input  wire logic [`DPC_ADDR_W-1:0] r_addr_in,
  output logic                        r_flag_n_out,
  input  wire logic                   inh_n_in,
  output logic [7:0]                  viol_cnt_out
);
  import dpc_pkg::*;
  logic [`DPC_DATA_W-1:0] mem [0:(1<<`DPC_ADDR_W)-1];
  logic [`DPC_DATA_W-1:0] last_v;
  realtime                l_t, r_t, w_t, fr_t;
  logic                   match, l_busy, sel_n, wr_n, lo_dev, hi_dev;

  // Clears the array and the time stamps.
  initial begin
    for (int i = 0; i < (1 << `DPC_ADDR_W); i++) mem[i] = 16'h0000;
    l_t  = 0.0;
    r_t  = 0.0;
    w_t  = 0.0;
    fr_t = 0.0;
    last_v = 16'h0000;
    viol_cnt_out = 8'h00;
  end

  // Arbitration: the port that was selected later loses; a tie flags the left port.
  assign sel_n  = pins_in.select_n;
  assign wr_n   = pins_in.lower_lane_write_n & pins_in.upper_lane_write_n;
  assign match  = !sel_n && !r_select_n_in && (pins_in.addr == r_addr_in);
  assign l_busy = match && (r_t <= l_t);
  assign flag_n_out   = l_busy ? 1'b0 : 1'b1;
  assign r_flag_n_out = (match && !l_busy) ? 1'b0 : 1'b1;

  // Records when each port became selected and when the left flag released.
  always @(negedge sel_n) l_t = $realtime;
  always @(negedge r_select_n_in) r_t = $realtime;
  always @(posedge flag_n_out) fr_t = $realtime;

  // Counts strobes that start before arbitration has settled.
  always @(negedge wr_n) begin
    w_t = $realtime;
    if ($realtime - l_t < ARB_NS) viol_cnt_out++;
  end

  // Counts strobes that end under a flag or too soon after its release.
  always @(posedge wr_n) begin
    if (!flag_n_out) viol_cnt_out++;
    else if (fr_t > w_t && $realtime - fr_t < HOLD_NS) viol_cnt_out++;
  end

  // Stores the written lanes while selected, not flagged and not inhibited from outside.
  always @(pins_in or dq_in or l_busy or inh_n_in) begin
    if (!sel_n && !l_busy && inh_n_in) begin
      if (!pins_in.lower_lane_write_n) mem[pins_in.addr][7:0] = dq_in[7:0];
      if (!pins_in.upper_lane_write_n) mem[pins_in.addr][15:8] = dq_in[15:8];
    end
  end

  // Drives lanes that are read; a released bus shows the inverse of its last value.
  assign lo_dev = !sel_n && !pins_in.out_enable_n && pins_in.lower_lane_write_n;
  assign hi_dev = !sel_n && !pins_in.out_enable_n && pins_in.upper_lane_write_n;
  assign dq_out[7:0]  = lo_dev ? mem[pins_in.addr][7:0] : !dq_oe_n_in ? dq_in[7:0] : ~last_v[7:0];
  assign dq_out[15:8] = hi_dev ? mem[pins_in.addr][15:8] : !dq_oe_n_in ? dq_in[15:8] : ~last_v[15:8];
  // Remembers each lane only while it is driven, so a floating lane cannot feed back on itself.
  always @(dq_out) begin
    if (lo_dev || !dq_oe_n_in) last_v[7:0] <= dq_out[7:0];
    if (hi_dev || !dq_oe_n_in) last_v[15:8] <= dq_out[15:8];
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`include "dpc_params.svh"

module tb_top;
  import dpc_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cmd_valid_in = 1'b0;
  dpc_cmd_s    cmd_in = '0;
  logic        ready_out, done_out, conflict_out, data_oe_n_out, flag_n, r_flag_n;
  logic [15:0] rdata_out, data_out, data_in, rd;
  logic        cf;
  dpc_pins_s   pins_out;
  logic        r_sel_n = 1'b1;
  logic [10:0] r_addr = 11'h000;
  logic [7:0]  viol;
  logic        ce = 1'b1;
  logic        inh_n = 1'b1;
  int          error_cnt = 0;
  int          n_compared = 0;

  // ----------------------------------------------------------------
  // Clock, design and device model.
  // ----------------------------------------------------------------
  always #2 clock_in = ~clock_in;

  dpc_port_ctrl DUT (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .ready_out(ready_out), .done_out(done_out), .conflict_out(conflict_out),
    .rdata_out(rdata_out), .pins_out(pins_out), .conflict_flag_n_in(flag_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n_out(data_oe_n_out));

  dpc_mem_model model (.pins_in(pins_out), .dq_in(data_out), .dq_oe_n_in(data_oe_n_out), .dq_out(data_in),
    .flag_n_out(flag_n), .r_select_n_in(r_sel_n), .r_addr_in(r_addr), .r_flag_n_out(r_flag_n),
    .inh_n_in(inh_n), .viol_cnt_out(viol));

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  // Compares a seen value with the expected one.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Runs one access and returns its read data and conflict report.
  task automatic access(input logic w, input logic [1:0] ln, input logic [10:0] a, input logic [15:0] d,
                        output logic [15:0] rdv, output logic cfv);
    int n;
    n = 0;
    @(posedge clock_in);
    #1;
    cmd_valid_in = 1'b1;
    cmd_in = '{write: w, lane: ln, addr: a, wdata: d};
    @(posedge clock_in);
    #1;
    cmd_valid_in = 1'b0;
    while (done_out !== 1'b1 && n < 300) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n >= 300) error_cnt++;
    rdv = rdata_out;
    cfv = conflict_out;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  // Full words at both ends of the array, read back.
  task t_full;
    access(1'b1, 2'h3, 11'h000, 16'hA5C3, rd, cf);
    access(1'b1, 2'h3, 11'h7FF, 16'h5A3C, rd, cf);
    access(1'b0, 2'h0, 11'h000, 16'h0000, rd, cf);
    check(rd, 16'hA5C3);
    access(1'b0, 2'h0, 11'h7FF, 16'h0000, rd, cf);
    check(rd, 16'h5A3C);
    check({15'h0000, cf}, 16'h0000);
  endtask

  // Single lane writes leave the other byte alone.
  task t_lanes;
    access(1'b1, 2'h3, 11'h010, 16'h0000, rd, cf);
    access(1'b1, 2'h1, 11'h010, 16'hABCD, rd, cf);
    access(1'b1, 2'h2, 11'h010, 16'h9876, rd, cf);
    access(1'b0, 2'h0, 11'h010, 16'h0000, rd, cf);
    check(rd, 16'h98CD);
  endtask

  // The far port at a neighbouring address causes no contention.
  task t_other;
    r_addr = 11'h100;
    r_sel_n = 1'b0;
    access(1'b1, 2'h3, 11'h101, 16'hBEEF, rd, cf);
    check({15'h0000, cf}, 16'h0000);
    r_sel_n = 1'b1;
    access(1'b0, 2'h0, 11'h101, 16'h0000, rd, cf);
    check(rd, 16'hBEEF);
  endtask

  // A write that loses arbitration is held off until the far port leaves.
  task t_conflict;
    access(1'b1, 2'h3, 11'h200, 16'h1111, rd, cf);
    r_addr = 11'h200;
    r_sel_n = 1'b0;
    fork
      access(1'b1, 2'h3, 11'h200, 16'h0F0F, rd, cf);
      begin
        repeat (30) @(posedge clock_in);
        #1;
        check(model.mem[11'h200], 16'h1111);
        check({14'h0000, flag_n, r_flag_n}, 16'h0001);
        r_sel_n = 1'b1;
      end
    join
    check({15'h0000, cf}, 16'h0001);
    check(model.mem[11'h200], 16'h0F0F);
  endtask

  // Reads racing the far port: the earlier party wins.
  task t_race(input logic dut_first);
    fork
      access(1'b0, 2'h0, 11'h200, 16'h0000, rd, cf);
      begin
        if (!dut_first) r_sel_n = 1'b0;
        repeat (12) @(posedge clock_in);
        #1;
        r_sel_n = 1'b0;
        repeat (12) @(posedge clock_in);
        #1;
        check({14'h0000, flag_n, r_flag_n}, dut_first ? 16'h0002 : 16'h0001);
        r_sel_n = 1'b1;
      end
    join
    check({15'h0000, cf}, {15'h0000, !dut_first});
    check(rd, 16'h0F0F);
  endtask

  // A low write-inhibit input blocks the write; released, writes land again.
  task t_inhibit;
    inh_n = 1'b0;
    access(1'b1, 2'h3, 11'h400, 16'h1234, rd, cf);
    check(model.mem[11'h400], 16'h0000);
    inh_n = 1'b1;
    access(1'b1, 2'h3, 11'h400, 16'h4321, rd, cf);
    check(model.mem[11'h400], 16'h4321);
  endtask

  // A low clock enable freezes a write with its strobe active, and the write then completes.
  task t_freeze;
    fork
      access(1'b1, 2'h3, 11'h300, 16'hCAFE, rd, cf);
      begin
        repeat (20) @(posedge clock_in);
        #1;
        ce = 1'b0;
        repeat (20) @(posedge clock_in);
        #1;
        check({1'b0, pins_out}, {1'b0, 11'h300, 4'h4});
        check({15'h0000, done_out}, 16'h0000);
        ce = 1'b1;
      end
    join
    check(model.mem[11'h300], 16'hCAFE);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    check({13'h0000, pins_out.select_n, ready_out, data_oe_n_out}, 16'h0007);
    t_full;
    t_lanes;
    t_other;
    t_conflict;
    t_race(1'b1);
    t_race(1'b0);
    t_inhibit;
    t_freeze;
    check({8'h00, viol}, 16'h0000);
    summarize;
  end

  // Cuts a hang short well after the expected run time.
  initial begin
    #40000;
    error_cnt++;
    summarize;
  end
endmodule
